// [hdl/smi_rise_detect.sv]
`timescale 1ns/1ps

module smi_rise_detect (
  input  wire logic core_clk,
  input  wire logic reset_n,
  input  wire logic level_in,
  output logic      rise
);

  logic prev_reg;

  // Held high at reset so a level already high is not an edge
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      prev_reg <= 1'b1;
    end else begin
      prev_reg <= level_in;
    end
  end

  assign rise = level_in & ~prev_reg;

endmodule

// [hdl/smi_status.sv]
`timescale 1ns/1ps
`include "smi_defines.svh"

// Operation
// - Status word bits 0 to 12 carry the per-function active flags in fixed order; 13 to 16 read zero.
// - Status word bits 17 to 23 carry alive test, SFR, all reached, SDC, operational, no encoder and no functional fault.
// - Status word bits 0 to 12, 19 and 23 equal the matching individual status outputs in every cycle; the other used bits have no individual output.
// - The state code output shows the monitor's current state.
// - Nothing is active while the activation input is low; the controller raises it to activate.
// - Safe homing starts only on a rising edge of the homing request.
// - A reset edge clears the error and restarts the monitor only once the fault cause is gone.
// - The reference switch marks the position reference during safe homing.
// - The reported state is that of the monitor held in this block.
// - State codes are 0000 idle, 8001 init, 8002 operational, 8003 waiting, 8000 safe, C000 fail.
// - The error output is high for Cxxx codes and low for 0xxx and 8xxx codes.
// - The error state is left only after a rising edge of the reset input, or when the activation input is low.
module smi_status
  import smi_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  input  wire logic        activate,
  input  wire logic        torque_off_request_n,
  input  wire logic        brake_control_request_n,
  input  wire logic        standstill_request_n,
  input  wire logic        stop1_request_n,
  input  wire logic        stop2_request_n,
  input  wire logic        speed_limit1_request_n,
  input  wire logic        speed_limit2_request_n,
  input  wire logic        speed_limit3_request_n,
  input  wire logic        speed_limit4_request_n,
  input  wire logic        torque_off_alt_request_n,
  input  wire logic        dir_positive_request_n,
  input  wire logic        increment_limit_request_n,
  input  wire logic        dir_negative_request_n,
  input  wire logic        position_limit_request_n,
  input  wire logic        home_request,
  input  wire logic        home_switch_in,
  input  wire logic        fault_reset,
  input  wire logic [15:0] axis_index,
  input  wire logic        auto_start,
  input  wire logic [13:0] function_reached,
  input  wire logic        fault_cause,
  input  wire logic        encoder_error,
  input  wire logic        alive_test_set_in,
  input  wire logic        sfr_in,
  input  wire logic        decel_monitor_in,
  output logic             ready,
  output logic [13:0]      function_active,
  output logic             position_valid,
  output logic             homing_busy,
  output logic             all_requested_reached,
  output logic             no_functional_fault,
  output logic             axis_assigned,
  output logic             error_out,
  output logic [15:0]      state_code,
  output logic [31:0]      combined_status_word
);

  smi_state_t  state_reg;
  smi_state_t  state_next;
  logic        home_rise;
  logic        reset_rise;
  logic [13:0] request_vec;
  logic        any_request;
  logic        all_reached;
  logic        run_state;
  logic [13:0] active_next;
  logic [15:0] code_next;
  logic [31:0] word_next;
  logic        homing_next;
  logic        valid_next;
  logic        oper_next;

  smi_rise_detect u_home_edge (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .level_in (home_request),
    .rise     (home_rise)
  );

  smi_rise_detect u_reset_edge (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .level_in (fault_reset),
    .rise     (reset_rise)
  );

  // Low level means requested
  assign request_vec = ~{position_limit_request_n, dir_negative_request_n,
                         increment_limit_request_n, dir_positive_request_n,
                         torque_off_alt_request_n, speed_limit4_request_n,
                         speed_limit3_request_n, speed_limit2_request_n,
                         speed_limit1_request_n, stop2_request_n, stop1_request_n,
                         standstill_request_n, brake_control_request_n,
                         torque_off_request_n};
  assign any_request = |request_vec;
  assign all_reached = &(~request_vec | function_reached);
  assign run_state   = (state_reg == SMI_OPER) || (state_reg == SMI_WAIT) ||
                       (state_reg == SMI_SAFE);

  // Monitor state machine
  always_comb begin
    state_next = state_reg;
    if (!activate) begin
      state_next = SMI_IDLE;
    end else begin
      unique case (state_reg)
        SMI_IDLE: state_next = SMI_INIT;
        SMI_INIT: begin
          if (fault_cause) begin
            state_next = SMI_FAIL;
          end else if (auto_start || reset_rise) begin
            state_next = SMI_OPER;
          end
        end
        SMI_OPER, SMI_WAIT, SMI_SAFE: begin
          if (fault_cause) begin
            state_next = SMI_FAIL;
          end else if (!any_request) begin
            state_next = SMI_OPER;
          end else if (all_reached) begin
            state_next = SMI_SAFE;
          end else begin
            state_next = SMI_WAIT;
          end
        end
        SMI_FAIL: begin
          if (reset_rise && !fault_cause) begin
            state_next = SMI_OPER;
          end
        end
        default: state_next = SMI_IDLE;
      endcase
    end
  end

  // State code decode
  assign code_next = (state_next == SMI_INIT) ? `SMI_CODE_INIT :
                     (state_next == SMI_OPER) ? `SMI_CODE_OPER :
                     (state_next == SMI_WAIT) ? `SMI_CODE_WAIT :
                     (state_next == SMI_SAFE) ? `SMI_CODE_SAFE :
                     (state_next == SMI_FAIL) ? `SMI_CODE_FAIL :
                     `SMI_CODE_IDLE;

  assign oper_next = (state_next == SMI_OPER) || (state_next == SMI_WAIT) ||
                     (state_next == SMI_SAFE);

  // Per-function flags, zero unless running
  genvar gi;
  generate
    for (gi = 0; gi < `SMI_FUNC_COUNT; gi = gi + 1) begin : g_func
      assign active_next[gi] = oper_next & request_vec[gi] & function_reached[gi];
    end
  endgenerate

  // Homing: started by edge, completed by reference switch
  assign homing_next = activate && run_state && !fault_cause &&
                       ((homing_busy && !home_switch_in) ||
                        (!homing_busy && home_rise));
  assign valid_next  = activate && !encoder_error && (state_next != SMI_FAIL) &&
                       (position_valid || (homing_busy && home_switch_in));

  // Status word built from the same next values as the flags
  assign word_next = {8'h00,
                      activate & (state_next != SMI_FAIL) & (state_next != SMI_IDLE),
                      activate & ~encoder_error,
                      oper_next,
                      activate & decel_monitor_in,
                      state_next == SMI_SAFE,
                      activate & sfr_in,
                      activate & alive_test_set_in,
                      4'h0,
                      active_next[`SMI_FUNC_BITS-1:0]};

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= SMI_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      ready                 <= 1'b0;
      function_active       <= 14'h0000;
      position_valid        <= 1'b0;
      homing_busy           <= 1'b0;
      all_requested_reached <= 1'b0;
      no_functional_fault   <= 1'b0;
      axis_assigned         <= 1'b0;
      error_out             <= 1'b0;
      state_code            <= `SMI_CODE_IDLE;
      combined_status_word  <= 32'h00000000;
    end else begin
      ready                 <= activate;
      function_active       <= active_next;
      position_valid        <= valid_next;
      homing_busy           <= homing_next;
      all_requested_reached <= word_next[`SMI_BIT_ALLREQ];
      no_functional_fault   <= word_next[`SMI_BIT_NOFUNC];
      axis_assigned         <= activate & (axis_index != `SMI_AXIS_NONE);
      error_out             <= code_next[15:14] == `SMI_ERR_PREFIX;
      state_code            <= code_next;
      combined_status_word  <= word_next;
    end
  end

  // Checks
  a_word_flags: assert property (@(posedge core_clk) disable iff (!reset_n)
    combined_status_word[12:0] == function_active[12:0] &&
    combined_status_word[`SMI_BIT_ALLREQ] == all_requested_reached &&
    combined_status_word[`SMI_BIT_NOFUNC] == no_functional_fault)
    else $error("status word differs from flags");
  a_unused_bits: assert property (@(posedge core_clk) disable iff (!reset_n)
    combined_status_word[16:13] == 4'h0 && combined_status_word[31:24] == 8'h00)
    else $error("unused status bits set");
  a_inactive_zero: assert property (@(posedge core_clk) disable iff (!reset_n)
    !activate |=> combined_status_word == 32'h0 && state_code == `SMI_CODE_IDLE
    && !ready)
    else $error("outputs not zero while inactive");
  a_error_code: assert property (@(posedge core_clk) disable iff (!reset_n)
    error_out == (state_code == `SMI_CODE_FAIL))
    else $error("error output disagrees with code");
  a_fail_hold: assert property (@(posedge core_clk) disable iff (!reset_n)
    error_out && activate && !reset_rise |=> error_out)
    else $error("error left without reset edge");
  a_fail_release: assert property (@(posedge core_clk) disable iff (!reset_n)
    error_out && activate && reset_rise && !fault_cause |=> !error_out
    && combined_status_word[`SMI_BIT_OPER])
    else $error("reset edge did not restart monitor");
  a_fail_flags: assert property (@(posedge core_clk) disable iff (!reset_n)
    error_out |-> !combined_status_word[`SMI_BIT_NOFUNC]
    && !combined_status_word[`SMI_BIT_OPER])
    else $error("flags wrong in fail state");
  a_home_edge: assert property (@(posedge core_clk) disable iff (!reset_n)
    $rose(homing_busy) |-> $past(home_request) && !$past(home_request, 2))
    else $error("homing started without edge");
  a_home_switch: assert property (@(posedge core_clk) disable iff (!reset_n)
    homing_busy && home_switch_in && activate && !encoder_error && !fault_cause
    |=> position_valid && !homing_busy)
    else $error("reference switch not taken");
  a_state_mirror: assert property (@(posedge core_clk) disable iff (!reset_n)
    (state_reg == SMI_SAFE) == (state_code == `SMI_CODE_SAFE) &&
    (state_reg == SMI_WAIT) == (state_code == `SMI_CODE_WAIT))
    else $error("state code not mirroring state");

  c_safe: cover property (@(posedge core_clk) disable iff (!reset_n)
    state_code == `SMI_CODE_WAIT ##[1:20] state_code == `SMI_CODE_SAFE);
  c_fail_reset: cover property (@(posedge core_clk) disable iff (!reset_n)
    error_out ##[1:20] !error_out && ready);
  c_homing: cover property (@(posedge core_clk) disable iff (!reset_n)
    homing_busy ##[1:20] position_valid);

endmodule

// [pkg/smi_defines.svh]
`ifndef SMI_DEFINES_SVH
`define SMI_DEFINES_SVH

// State codes
`define SMI_CODE_IDLE    16'h0000
`define SMI_CODE_INIT    16'h8001
`define SMI_CODE_OPER    16'h8002
`define SMI_CODE_WAIT    16'h8003
`define SMI_CODE_SAFE    16'h8000
`define SMI_CODE_FAIL    16'hC000

// Error range prefix in the top two code bits
`define SMI_ERR_PREFIX   2'h3

// Status word layout
`define SMI_FUNC_COUNT   14
`define SMI_FUNC_BITS    13
`define SMI_BIT_ALIVE    17
`define SMI_BIT_SFR      18
`define SMI_BIT_ALLREQ   19
`define SMI_BIT_SDC      20
`define SMI_BIT_OPER     21
`define SMI_BIT_NOENC    22
`define SMI_BIT_NOFUNC   23

// Axis index meaning no axis
`define SMI_AXIS_NONE    16'hFFFF

`endif

// [pkg/smi_pkg.sv]
package smi_pkg;

  typedef enum logic [2:0] {
    SMI_IDLE,
    SMI_INIT,
    SMI_OPER,
    SMI_WAIT,
    SMI_SAFE,
    SMI_FAIL
  } smi_state_t;

endpackage

// [test/safe_motion_status_interface_test.sv]
`timescale 1ns/1ps
`include "smi_defines.svh"

module safe_motion_status_interface_test;
  logic        core_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        auto_start = 1'b0, fault_cause = 1'b0, encoder_error = 1'b0;
  logic        alive_test_set_in = 1'b0, sfr_in = 1'b0, decel_monitor_in = 1'b0;
  logic [13:0] function_reached = 14'h0000;
  logic        activate, home_request, home_switch_in, fault_reset;
  logic [13:0] request_n;
  logic [15:0] axis_index;
  logic        ready, position_valid, homing_busy, all_requested_reached;
  logic        no_functional_fault, axis_assigned, error_out;
  logic [13:0] function_active;
  logic [15:0] state_code;
  logic [31:0] combined_status_word;
  int          num_errors = 0, checks = 0, cycles = 0, st, nx;
  logic [31:0] seed = 32'h84412761, ew;
  logic [13:0] fa, rq;
  logic        hb, pv, rdy, ph, pr, rr, hr, run, nrun, aa;
  logic [15:0] codes [6] = '{`SMI_CODE_IDLE, `SMI_CODE_INIT, `SMI_CODE_OPER, `SMI_CODE_WAIT,
                             `SMI_CODE_SAFE, `SMI_CODE_FAIL};

  smi_controller smi_controller_inst (.activate, .request_n, .home_request, .home_switch_in,
    .fault_reset, .axis_index);

  smi_status smi_status_inst (.core_clk, .reset_n, .activate,
    .torque_off_request_n(request_n[0]), .brake_control_request_n(request_n[1]),
    .standstill_request_n(request_n[2]), .stop1_request_n(request_n[3]),
    .stop2_request_n(request_n[4]), .speed_limit1_request_n(request_n[5]),
    .speed_limit2_request_n(request_n[6]), .speed_limit3_request_n(request_n[7]),
    .speed_limit4_request_n(request_n[8]), .torque_off_alt_request_n(request_n[9]),
    .dir_positive_request_n(request_n[10]), .increment_limit_request_n(request_n[11]),
    .dir_negative_request_n(request_n[12]), .position_limit_request_n(request_n[13]),
    .home_request, .home_switch_in, .fault_reset, .axis_index, .auto_start, .function_reached,
    .fault_cause, .encoder_error, .alive_test_set_in, .sfr_in, .decel_monitor_in, .ready,
    .function_active, .position_valid, .homing_busy, .all_requested_reached,
    .no_functional_fault, .axis_assigned, .error_out, .state_code, .combined_status_word);

  initial begin
    forever #25 core_clk = ~core_clk;
  end

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic conclude();
    $display("checks=%0d num_errors=%0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #2;
  endtask

  task automatic rnd(input logic act);
    seed = lfsr_next(seed);
    {alive_test_set_in, sfr_in, decel_monitor_in, encoder_error} = seed[17:14];
    function_reached = seed[13:0];
    smi_controller_inst.put(act, seed[31:18], 1'b0, 1'b0, 1'b0);
  endtask

  // Reference model, updated at every edge and compared just after it
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      st = 0; fa = '0; hb = 0; pv = 0; rdy = 0; ph = 1; pr = 1; ew = '0;
      aa = 0;
    end else begin
      rr = fault_reset & ~pr;
      hr = home_request & ~ph;
      pr = fault_reset;
      ph = home_request;
      rq = ~request_n;
      run = st >= 2 && st <= 4;
      if (!activate) nx = 0;
      else if (st == 0) nx = 1;
      else if (fault_cause && st != 5) nx = 5;
      else if (run) nx = (rq == 0) ? 2 : (((rq & ~function_reached) == 0) ? 4 : 3);
      else if ((st == 1 && (auto_start || rr)) || (st == 5 && rr && !fault_cause)) nx = 2;
      else nx = st;
      nrun = nx >= 2 && nx <= 4;
      fa = nrun ? (rq & function_reached) : '0;
      if (!activate || nx == 5) begin
        hb = 0; pv = 0;
      end else if (hb && home_switch_in) begin
        hb = 0; pv = 1;
      end else if (hr && run && !fault_cause && !hb) hb = 1;
      if (encoder_error) pv = 0;
      ew = {8'h00, activate && nx != 5 && nx != 0, activate & ~encoder_error, nrun,
            activate & decel_monitor_in, nx == 4, activate & sfr_in, activate & alive_test_set_in,
            4'h0, fa[12:0]};
      rdy = activate;
      aa = activate && axis_index != `SMI_AXIS_NONE;
      st = nx;
    end
    #1;
    chk("ready", {31'h0, rdy}, {31'h0, ready});
    chk("state_code", {16'h0, codes[st]}, {16'h0, state_code});
    chk("error_out", {31'h0, st == 5}, {31'h0, error_out});
    chk("function_active", {18'h0, fa}, {18'h0, function_active});
    chk("status_word", ew, combined_status_word);
    chk("homing", {30'h0, hb, pv}, {30'h0, homing_busy, position_valid});
    chk("flag_pair", {30'h0, ew[19], ew[23]},
        {30'h0, all_requested_reached, no_functional_fault});
    chk("active_bits", {19'h0, fa[12:0]}, {19'h0, combined_status_word[12:0]});
    chk("axis_assigned", {31'h0, aa}, {31'h0, axis_assigned});
  end

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      num_errors++;
      conclude();
    end
  end

  initial begin
    cyc(5);
    reset_n = 1'b1;
    repeat (20) begin rnd(1'b0); cyc(1); end
    {alive_test_set_in, sfr_in, decel_monitor_in, encoder_error, function_reached} = '0;
    smi_controller_inst.put(1'b1, 14'h3FFF, 1'b0, 1'b0, 1'b0); cyc(4);
    smi_controller_inst.put(1'b1, 14'h3FFF, 1'b0, 1'b0, 1'b1); cyc(2);
    smi_controller_inst.put(1'b0, 14'h3FFF, 1'b0, 1'b0, 1'b0); cyc(2);
    auto_start = 1'b1;
    smi_controller_inst.put(1'b1, 14'h3FFF, 1'b0, 1'b0, 1'b0); cyc(3);
    for (int i = 0; i < 14; i++) begin
      function_reached = '0;
      smi_controller_inst.put(1'b1, ~(14'h0001 << i), 1'b0, 1'b0, 1'b0); cyc(2);
      function_reached = 14'h0001 << i; cyc(2);
    end
    repeat (300) begin rnd(1'b1); cyc(1); end
    {alive_test_set_in, sfr_in, decel_monitor_in, encoder_error, function_reached} = '0;
    smi_controller_inst.put(1'b1, 14'h3FFF, 1'b0, 1'b0, 1'b0); cyc(2);
    smi_controller_inst.put(1'b1, 14'h3FFF, 1'b1, 1'b0, 1'b0); cyc(3);
    smi_controller_inst.put(1'b1, 14'h3FFF, 1'b1, 1'b1, 1'b0); cyc(2);
    smi_controller_inst.put(1'b1, 14'h3FFF, 1'b1, 1'b0, 1'b0); cyc(3);
    smi_controller_inst.put(1'b1, 14'h3FFF, 1'b0, 1'b0, 1'b0); cyc(1);
    smi_controller_inst.put(1'b1, 14'h3FFF, 1'b1, 1'b0, 1'b0); cyc(2);
    smi_controller_inst.put(1'b1, 14'h3FFF, 1'b1, 1'b1, 1'b0); cyc(2);
    encoder_error = 1'b1; cyc(2);
    encoder_error = 1'b0;
    fault_cause = 1'b1; cyc(2);
    smi_controller_inst.put(1'b1, 14'h3FFF, 1'b0, 1'b0, 1'b1); cyc(2);
    fault_cause = 1'b0;
    smi_controller_inst.put(1'b1, 14'h3FFF, 1'b0, 1'b0, 1'b0); cyc(3);
    smi_controller_inst.put(1'b1, 14'h3FFF, 1'b0, 1'b0, 1'b1); cyc(2);
    auto_start = 1'b0;
    smi_controller_inst.put(1'b0, 14'h3FFF, 1'b0, 1'b0, 1'b0); cyc(2);
    smi_controller_inst.put(1'b1, 14'h3FFF, 1'b0, 1'b0, 1'b0); cyc(3);
    fault_cause = 1'b1; cyc(2);
    fault_cause = 1'b0;
    smi_controller_inst.put(1'b1, 14'h3FFF, 1'b0, 1'b0, 1'b1); cyc(2);
    reset_n = 1'b0; cyc(2);
    reset_n = 1'b1; cyc(3);
    smi_controller_inst.put(1'b1, 14'h3FFE, 1'b0, 1'b0, 1'b0); cyc(2);
    smi_controller_inst.put(1'b1, 14'h3FFE, 1'b0, 1'b0, 1'b1); cyc(3);
    smi_controller_inst.set_axis(`SMI_AXIS_NONE); cyc(2);
    smi_controller_inst.put(1'b0, 14'h3FFF, 1'b0, 1'b0, 1'b0); cyc(3);
    conclude();
  end
endmodule

// [test/smi_controller.sv]
`timescale 1ns/1ps

// Controller application model: activation, requests, homing, reset edge, axis
module smi_controller #(
  parameter logic [15:0] AXIS_ID = 16'h0003
) (
  output logic        activate,
  output logic [13:0] request_n,
  output logic        home_request,
  output logic        home_switch_in,
  output logic        fault_reset,
  output logic [15:0] axis_index
);
  initial begin
    axis_index = AXIS_ID;
    activate = 1'b0;
    request_n = 14'h0000;
    home_request = 1'b0;
    home_switch_in = 1'b0;
    fault_reset = 1'b0;
  end

  // Levels change only when the bench calls this just after a clock edge
  task automatic put(input logic act, input logic [13:0] req, input logic hr, input logic hs,
                     input logic fr);
    activate = act;
    request_n = req;
    home_request = hr;
    home_switch_in = hs;
    fault_reset = fr;
  endtask

  // Axis constant swapped only between configurations
  task automatic set_axis(input logic [15:0] id);
    axis_index = id;
  endtask
endmodule
